// *** rtl/gpirq_pkg.sv ***
// Purpose: shared constants for the pin event type and misc control registers
// Assumes: byte addresses in configuration space, 32-bit data words
// Notes: offsets, status field positions, reset values and widths live here; control bit indices sit in the top module
`default_nettype none

package gpirq_pkg;

    // configuration space layout
    localparam int unsigned GPIRQ_ADDR_W = 8;
    localparam int unsigned GPIRQ_DATA_W = 32;
    localparam logic [7:0] GPIRQ_OFS_EVENT_TYPE = 8'h48;
    localparam logic [7:0] GPIRQ_OFS_MISC = 8'h4C;

    // event type register fields
    localparam int unsigned GPIRQ_EVT_W = 8;
    localparam int unsigned GPIRQ_EVT_PIN2_BIT = 2;
    localparam int unsigned GPIRQ_EVT_PIN3_BIT = 3;
    localparam logic [7:0] GPIRQ_EVT_RESET = 8'h00;

    // misc control register fields
    localparam int unsigned GPIRQ_MISC_W = 16;
    localparam int unsigned GPIRQ_MISC_PRESENT_BIT = 15;
    localparam int unsigned GPIRQ_MISC_ERROR_BIT = 14;
    localparam int unsigned GPIRQ_MISC_BUSY_BIT = 13;
    localparam int unsigned GPIRQ_MISC_SWITCH_BIT = 8;
    localparam int unsigned GPIRQ_MISC_CTRL_W = 6;
    localparam logic [15:0] GPIRQ_MISC_RESET = 16'h000F;

    // interrupt event register positions of the two pin flags
    localparam int unsigned GPIRQ_FLAG_PIN2_BIT = 27;
    localparam int unsigned GPIRQ_FLAG_PIN3_BIT = 28;

    // number of event-capable pins and synchroniser depth
    localparam int unsigned GPIRQ_NPINS = 2;
    localparam int unsigned GPIRQ_SYNC_STAGES = 2;

endpackage

`default_nettype wire

// *** rtl/gpirq_evt_if.sv ***
// Purpose: carrier between the register core and the pin event detector
// Assumes: one clock domain, index 0 is pin 2 and index 1 is pin 3
// Notes: the core drives configuration and levels, the detector the flags
`timescale 1ns/100ps
`default_nettype none

interface gpirq_evt_if #(
    parameter int unsigned NPINS = 2
);
    logic [NPINS-1:0] event_type;
    logic [NPINS-1:0] event_input_sel;
    logic [NPINS-1:0] pin_level;
    logic [NPINS-1:0] flag_set;

    modport core (
        output event_type,
        output event_input_sel,
        output pin_level,
        input flag_set
    );

    modport detector (
        input event_type,
        input event_input_sel,
        input pin_level,
        output flag_set
    );
endinterface

`default_nettype wire

// *** rtl/gpirq_sync.sv ***
// Purpose: multi-bit level synchroniser for asynchronous pin inputs
// Assumes: each bit is an independent level, no word coherence needed
// Notes: only the last stage may be read by downstream logic
`timescale 1ns/100ps
`default_nettype none

module gpirq_sync
    import gpirq_pkg::*;
#(
    parameter int unsigned WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // raw and synchronised levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // first stage feeds the second stage only, to contain metastability
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            stage1 <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else if (clk_en) begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

// *** rtl/gpirq_event.sv ***
// Purpose: per-pin low-level or change-of-state event detection
// Assumes: pin levels arrive already synchronised to sys_clk
// Notes: flag_set is a registered one-cycle pulse per qualifying sample
`timescale 1ns/100ps
`default_nettype none

module gpirq_event
    import gpirq_pkg::*;
#(
    parameter int unsigned NPINS = 2
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // configuration, levels and flags
    gpirq_evt_if.detector evt
);

    logic [NPINS-1:0] prev_level;
    logic primed;
    wire [NPINS-1:0] hit_vec;

    // primed blocks a false change right after reset, when prev still holds its reset zero
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            prev_level <= '0;
            primed <= 1'b0;
        end else if (clk_en) begin
            prev_level <= evt.pin_level;
            primed <= 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_pin
            wire level_low;
            wire changed;
            // level mode repeats every cycle the pin stays low
            assign level_low = ~evt.pin_level[gi];
            assign changed = primed & (evt.pin_level[gi] ^ prev_level[gi]);
            assign hit_vec[gi] = evt.event_input_sel[gi] &
                (evt.event_type[gi] ? changed : level_low);
        end
    endgenerate

    // one flop bank keeps every flag bit under a single driver
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            evt.flag_set <= '0;
        end else if (clk_en) begin
            evt.flag_set <= hit_vec;
        end
    end

endmodule

`default_nettype wire

// *** rtl/gpirq_top.sv ***
// Purpose: pin event type and miscellaneous control registers of the bridge
// Assumes: configuration cycles arrive as single-cycle strobes on sys_clk
// Notes: present, busy and switch bits are live, error is sticky; control and event type bits hold written state
//
// Summary of operation
// - type 0: pin 3 low sets bit 28
// - type 1: pin 3 change sets bit 28
// - pin 2 type selects level or change
// - event type reserved bits read zero
// - bit 15 shows eeprom detected, read-only
// - bit 14 eeprom error, write one clears
// - bit 13 shows eeprom busy, read-only
// - bit 8 returns handle switch level
// - bit 5 enables the auxiliary bus
// - bit 4 selects power management layout
// - bit 3 enables hot insertion support
// - bit 2 locks cold wake support bit
// - bit 1 enables posted writes
// - bit 0 protects subsystem id registers
// - misc reserved bits read zero
// - bus enable turns pins 5,4 into strobes
// - flags only when pin selected as event
`timescale 1ns/100ps
`default_nettype none

module gpirq_top
    import gpirq_pkg::*;
(
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // configuration access
    input wire logic [GPIRQ_ADDR_W-1:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [GPIRQ_DATA_W-1:0] cfg_wdata,
    output logic [GPIRQ_DATA_W-1:0] cfg_rdata,
    output logic cfg_ack,
    // pins from outside the clock domain
    input wire logic gpio2_pin,
    input wire logic gpio3_pin,
    input wire logic handle_switch_input,
    // pin select register, same clock
    input wire logic pin2_is_event_input,
    input wire logic pin3_is_event_input,
    // serial eeprom loader status, same clock
    input wire logic eeprom_present,
    input wire logic eeprom_busy,
    input wire logic eeprom_error_event,
    // interrupt event register set pulses
    output logic pin2_event_flag,
    output logic pin3_event_flag,
    // configuration outputs to the rest of the bridge
    output logic aux_bus_enable,
    output logic aux_bus_read_strobe,
    output logic aux_bus_write_strobe,
    output logic pm_v11_layout_select,
    output logic hot_insert_enable,
    output logic cold_wake_lock,
    output logic posted_write_control,
    output logic subsys_id_write_protect
);

    // index of each control bit inside the misc register
    localparam int unsigned CTRL_SUBSYS = 0;
    localparam int unsigned CTRL_POSTED = 1;
    localparam int unsigned CTRL_COLD = 2;
    localparam int unsigned CTRL_HOTINS = 3;
    localparam int unsigned CTRL_PM11 = 4;
    localparam int unsigned CTRL_AUXBUS = 5;

    // ------------------------------------------------------------------
    // registered state
    logic [GPIRQ_NPINS-1:0] event_type;
    logic [GPIRQ_MISC_CTRL_W-1:0] misc_ctrl;
    logic eeprom_error;
    logic [GPIRQ_NPINS-1:0] pin_sync;
    logic handle_switch_sync;
    logic [2:0] sync_bus;

    // next values
    logic [GPIRQ_NPINS-1:0] next_event_type;
    logic [GPIRQ_MISC_CTRL_W-1:0] next_misc_ctrl;
    logic next_eeprom_error;
    logic [GPIRQ_DATA_W-1:0] next_rdata;

    // ------------------------------------------------------------------
    // pin synchronisers: gpio2, gpio3 and the handle switch share one bank
    gpirq_sync #(
        .WIDTH(3),
        .RESET_VAL(3'h0)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .async_in({handle_switch_input, gpio3_pin, gpio2_pin}),
        .sync_out(sync_bus)
    );

    assign pin_sync = sync_bus[1:0];
    assign handle_switch_sync = sync_bus[2];

    // ------------------------------------------------------------------
    // event detector for pins 2 and 3
    gpirq_evt_if #(.NPINS(GPIRQ_NPINS)) evt_bus ();

    assign evt_bus.event_type = event_type;
    assign evt_bus.event_input_sel = {pin3_is_event_input, pin2_is_event_input};
    assign evt_bus.pin_level = pin_sync;

    gpirq_event #(
        .NPINS(GPIRQ_NPINS)
    ) u_event (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .evt(evt_bus.detector)
    );

    // flags leave the detector flops without further logic
    assign pin2_event_flag = evt_bus.flag_set[0];
    assign pin3_event_flag = evt_bus.flag_set[1];

    // ------------------------------------------------------------------
    // address decode and byte lane qualification
    wire hit_event_type;
    wire hit_misc;
    wire wr_event_lane0;
    wire wr_misc_lane0;
    wire wr_misc_lane1;
    wire rd_any;

    assign hit_event_type = (cfg_addr == GPIRQ_OFS_EVENT_TYPE);
    assign hit_misc = (cfg_addr == GPIRQ_OFS_MISC);
    assign wr_event_lane0 = cfg_wr & hit_event_type & cfg_byte_en[0];
    assign wr_misc_lane0 = cfg_wr & hit_misc & cfg_byte_en[0];
    assign wr_misc_lane1 = cfg_wr & hit_misc & cfg_byte_en[1];
    assign rd_any = cfg_rd | cfg_wr;

    // ------------------------------------------------------------------
    // event type register: only bits 3 and 2 hold state
    wire [1:0] wdata_event_type;

    assign wdata_event_type = {cfg_wdata[GPIRQ_EVT_PIN3_BIT], cfg_wdata[GPIRQ_EVT_PIN2_BIT]};

    always_comb begin
        next_event_type = event_type;
        if (wr_event_lane0) begin
            next_event_type = wdata_event_type;
        end
    end

    // ------------------------------------------------------------------
    // misc control bits 5..0 live in byte lane 0
    always_comb begin
        next_misc_ctrl = misc_ctrl;
        if (wr_misc_lane0) begin
            next_misc_ctrl = cfg_wdata[GPIRQ_MISC_CTRL_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // eeprom error: a new error in the clearing cycle wins, so none is lost
    wire error_clear;

    assign error_clear = wr_misc_lane1 & cfg_wdata[GPIRQ_MISC_ERROR_BIT];

    always_comb begin
        next_eeprom_error = eeprom_error;
        if (error_clear) begin
            next_eeprom_error = 1'b0;
        end
        if (eeprom_error_event) begin
            next_eeprom_error = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // read views: reserved positions are hard zeros
    wire [GPIRQ_EVT_W-1:0] event_type_view;
    wire [GPIRQ_MISC_W-1:0] misc_view;

    assign event_type_view = {4'h0, event_type, 2'h0};
    assign misc_view = {
        eeprom_present,
        eeprom_error,
        eeprom_busy,
        4'h0,
        handle_switch_sync,
        2'h0,
        misc_ctrl
    };

    // unmapped addresses return zero; a write also returns the old contents
    always_comb begin
        next_rdata = '0;
        if (hit_event_type) begin
            next_rdata = {24'h000000, event_type_view};
        end else if (hit_misc) begin
            next_rdata = {16'h0000, misc_view};
        end
    end

    // ------------------------------------------------------------------
    // event type bits, frozen while clk_en is low
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            event_type <= GPIRQ_EVT_RESET[GPIRQ_EVT_PIN3_BIT:GPIRQ_EVT_PIN2_BIT];
        end else if (clk_en) begin
            event_type <= next_event_type;
        end
    end

    // writable misc control bits
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            misc_ctrl <= GPIRQ_MISC_RESET[GPIRQ_MISC_CTRL_W-1:0];
        end else if (clk_en) begin
            misc_ctrl <= next_misc_ctrl;
        end
    end

    // sticky eeprom error status
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            eeprom_error <= GPIRQ_MISC_RESET[GPIRQ_MISC_ERROR_BIT];
        end else if (clk_en) begin
            eeprom_error <= next_eeprom_error;
        end
    end

    // ------------------------------------------------------------------
    // read answer, one cycle after the strobe; zero outside the ack cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cfg_rdata <= '0;
        end else if (clk_en) begin
            cfg_rdata <= rd_any ? next_rdata : '0;
        end
    end

    // every taken strobe is answered, writes included
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cfg_ack <= 1'b0;
        end else if (clk_en) begin
            cfg_ack <= rd_any;
        end
    end

    // ------------------------------------------------------------------
    // control bit values as they will stand after this edge;
    // the output copies load these so they never lag the register
    wire next_aux_enable;
    wire next_pm11;
    wire next_hotins;
    wire next_cold;
    wire next_posted;
    wire next_subsys;

    assign next_aux_enable = next_misc_ctrl[CTRL_AUXBUS];
    assign next_pm11 = next_misc_ctrl[CTRL_PM11];
    assign next_hotins = next_misc_ctrl[CTRL_HOTINS];
    assign next_cold = next_misc_ctrl[CTRL_COLD];
    assign next_posted = next_misc_ctrl[CTRL_POSTED];
    assign next_subsys = next_misc_ctrl[CTRL_SUBSYS];

    // auxiliary bus enable
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            aux_bus_enable <= GPIRQ_MISC_RESET[CTRL_AUXBUS];
        end else if (clk_en) begin
            aux_bus_enable <= next_aux_enable;
        end
    end

    // pin 5 turns into the read strobe with the bus;
    // clearing the enable hands the pin back to plain data
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            aux_bus_read_strobe <= GPIRQ_MISC_RESET[CTRL_AUXBUS];
        end else if (clk_en) begin
            aux_bus_read_strobe <= next_aux_enable;
        end
    end

    // pin 4 turns into the write strobe with the bus
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            aux_bus_write_strobe <= GPIRQ_MISC_RESET[CTRL_AUXBUS];
        end else if (clk_en) begin
            aux_bus_write_strobe <= next_aux_enable;
        end
    end

    // power management layout select
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pm_v11_layout_select <= GPIRQ_MISC_RESET[CTRL_PM11];
        end else if (clk_en) begin
            pm_v11_layout_select <= next_pm11;
        end
    end

    // hot insertion support
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            hot_insert_enable <= GPIRQ_MISC_RESET[CTRL_HOTINS];
        end else if (clk_en) begin
            hot_insert_enable <= next_hotins;
        end
    end

    // cold wake support lock
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cold_wake_lock <= GPIRQ_MISC_RESET[CTRL_COLD];
        end else if (clk_en) begin
            cold_wake_lock <= next_cold;
        end
    end

    // posted write control
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            posted_write_control <= GPIRQ_MISC_RESET[CTRL_POSTED];
        end else if (clk_en) begin
            posted_write_control <= next_posted;
        end
    end

    // subsystem id write protection
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            subsys_id_write_protect <= GPIRQ_MISC_RESET[CTRL_SUBSYS];
        end else if (clk_en) begin
            subsys_id_write_protect <= next_subsys;
        end
    end

endmodule

`default_nettype wire

// *** bench/gpirq_top_properties.sv ***
// Purpose: port-level checks of the pin event and misc control registers
// Assumes: one clock, reads answered one cycle after the taken strobe
// Notes: the switch check needs clk_en high around misc reads
`timescale 1ns/100ps
`default_nettype none

module gpirq_top_properties
    import gpirq_pkg::*;
(
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // configuration access
    input wire logic [GPIRQ_ADDR_W-1:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [GPIRQ_DATA_W-1:0] cfg_wdata,
    input wire logic [GPIRQ_DATA_W-1:0] cfg_rdata,
    input wire logic cfg_ack,
    // levels from outside
    input wire logic handle_switch_input,
    input wire logic pin2_is_event_input,
    input wire logic pin3_is_event_input,
    input wire logic eeprom_present,
    input wire logic eeprom_busy,
    input wire logic eeprom_error_event,
    // outputs watched
    input wire logic pin2_event_flag,
    input wire logic pin3_event_flag,
    input wire logic aux_bus_enable,
    input wire logic aux_bus_read_strobe,
    input wire logic aux_bus_write_strobe,
    input wire logic pm_v11_layout_select,
    input wire logic hot_insert_enable,
    input wire logic cold_wake_lock,
    input wire logic posted_write_control,
    input wire logic subsys_id_write_protect
);
    // plain reads only, so the returned word is never mixed with a write
    wire logic rd_evt = clk_en && cfg_rd && !cfg_wr && cfg_addr == GPIRQ_OFS_EVENT_TYPE;
    wire logic rd_misc = clk_en && cfg_rd && !cfg_wr && cfg_addr == GPIRQ_OFS_MISC;
    wire logic wr_misc = clk_en && cfg_wr && cfg_addr == GPIRQ_OFS_MISC;
    wire logic [5:0] wd_ctl = cfg_wdata[5:0];
    wire logic [5:0] ctl = {aux_bus_enable, pm_v11_layout_select, hot_insert_enable,
        cold_wake_lock, posted_write_control, subsys_id_write_protect};

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // error status steps: set by the loader, cleared by a one in lane 1
    sequence err_seen;
        clk_en && eeprom_error_event ##1 rd_misc;
    endsequence
    sequence err_cleared;
        wr_misc && cfg_byte_en[1] && cfg_wdata[14] && !eeprom_error_event
            ##1 rd_misc && !eeprom_error_event;
    endsequence

    evt_reserved_a:
        assert property (rd_evt |=> cfg_ack && cfg_rdata[31:4] == 28'h0 && cfg_rdata[1:0] == 2'h0)
        else $error("event type reserved bits not zero");
    misc_reserved_a:
        assert property (rd_misc |=> cfg_rdata[31:16] == 16'h0 && cfg_rdata[12:9] == 4'h0
            && cfg_rdata[7:6] == 2'h0)
        else $error("misc reserved bits not zero");
    status_live_a:
        assert property (rd_misc |=> cfg_rdata[15] == $past(eeprom_present)
            && cfg_rdata[13] == $past(eeprom_busy))
        else $error("eeprom status not live");
    switch_level_a:
        assert property (rd_misc |=> cfg_rdata[8] == $past(handle_switch_input, 3))
        else $error("switch status wrong");
    ctrl_readback_a:
        assert property (rd_misc |=> cfg_rdata[5:0] == ctl)
        else $error("control bits read back wrong");
    ctrl_write_a:
        assert property (wr_misc && cfg_byte_en[0] |=> ctl == $past(wd_ctl))
        else $error("control write not taken");
    strobe_follow_a:
        assert property (aux_bus_read_strobe == aux_bus_enable
            && aux_bus_write_strobe == aux_bus_enable)
        else $error("strobe selects differ from bus enable");
    error_sticky_a:
        assert property (err_seen |=> cfg_rdata[14])
        else $error("error status not set");
    error_clear_a:
        assert property (err_cleared |=> !cfg_rdata[14])
        else $error("error status not cleared");
    select_gate_a:
        assert property ($past(clk_en) |-> (pin2_event_flag -> $past(pin2_is_event_input))
            && (pin3_event_flag -> $past(pin3_is_event_input)))
        else $error("flag without event select");
endmodule

bind gpirq_top gpirq_top_properties u_gpirq_top_properties (.*);

`default_nettype wire

// *** bench/tb_top.sv ***
// Purpose: self-checking bench for gpirq_top
// Assumes: one-cycle ack per taken strobe, two-flop pin synchronisers
// Notes: each access notes its expected answer, a monitor checks it on ack
`timescale 1ns/100ps
`default_nettype none

module tb_top
    import gpirq_pkg::*;
;
    // stimulus, changed on the falling edge only
    logic sys_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_byte_en = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic gpio2_pin = 1'b1, gpio3_pin = 1'b1, handle_switch_input = 1'b0;
    logic pin2_is_event_input = 1'b0, pin3_is_event_input = 1'b0;
    logic eeprom_present = 1'b0, eeprom_busy = 1'b0, eeprom_error_event = 1'b0;
    // design outputs
    wire logic [31:0] cfg_rdata;
    wire logic cfg_ack, pin2_event_flag, pin3_event_flag, aux_bus_enable;
    wire logic aux_bus_read_strobe, aux_bus_write_strobe, pm_v11_layout_select;
    wire logic hot_insert_enable, cold_wake_lock, posted_write_control, subsys_id_write_protect;
    wire logic [5:0] ctl_out = {aux_bus_enable, pm_v11_layout_select, hot_insert_enable,
        cold_wake_lock, posted_write_control, subsys_id_write_protect};
    // register model and bookkeeping
    logic [5:0] ctl = 6'h0F;
    logic [1:0] ev = 2'h0;
    logic err = 1'b0;
    logic [7:0] rnd = 8'h1E;
    logic [63:0] note;
    logic [63:0] exp_q[$];
    int n_fail = 0;
    int checks_done = 0;

    gpirq_top u_gpirq_top (.*);

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // expected misc word from the model and the levels driven now
    function automatic logic [31:0] mexp();
        return {16'h0, eeprom_present, err, eeprom_busy, 4'h0, handle_switch_input, 2'h0, ctl};
    endfunction

    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic results();
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one strobe; held until the next access or idle, so accesses may run back to back
    task automatic acc(input logic r, input logic w, input logic [7:0] a,
        input logic [3:0] be, input logic [31:0] d, input logic [63:0] n);
        @(negedge sys_clk);
        cfg_rd = r;
        cfg_wr = w;
        cfg_addr = a;
        cfg_byte_en = be;
        cfg_wdata = d;
        if (clk_en) begin
            exp_q.push_back(n);
        end
    endtask

    task automatic idle();
        @(negedge sys_clk);
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
    endtask

    // a write answers with data we do not judge, hence the zero mask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        acc(1'b0, 1'b1, a, be, d, 64'h0);
        ctl = (clk_en && be[0] && a == GPIRQ_OFS_MISC) ? d[5:0] : ctl;
        err = (clk_en && be[1] && d[14] && a == GPIRQ_OFS_MISC) ? eeprom_error_event : err;
        ev = (clk_en && be[0] && a == GPIRQ_OFS_EVENT_TYPE) ? d[3:2] : ev;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        acc(1'b1, 1'b0, a, 4'hF, 32'h0, {32'hFFFFFFFF, e});
    endtask

    // every answer is matched against the oldest note
    always @(posedge sys_clk) begin
        #1;
        if (cfg_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(1'b0, "ack without request");
            end else begin
                note = exp_q.pop_front();
                chk((cfg_rdata & note[63:32]) === note[31:0], "read data");
            end
        end
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        chk(1'b0, "run too long");
        results();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (3) idle();
        chk(ctl_out === 6'h0F, "control reset");
        rd(GPIRQ_OFS_EVENT_TYPE, 32'h0);
        rd(GPIRQ_OFS_MISC, mexp());
        idle();
        // random lanes and data, unmapped accesses mixed in back to back
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            eeprom_present = rnd[0];
            eeprom_busy = rnd[1];
            handle_switch_input = rnd[2];
            repeat (3) idle();
            wr(GPIRQ_OFS_MISC, rnd[7:4], {16'h0, rnd, rnd});
            wr({1'b1, rnd[6:0]}, 4'hF, 32'hFFFFFFFF);
            rd(GPIRQ_OFS_MISC, mexp());
            wr(GPIRQ_OFS_EVENT_TYPE, rnd[3:0], {24'h0, ~rnd});
            rd({1'b1, rnd[6:0]}, 32'h0);
            rd(GPIRQ_OFS_EVENT_TYPE, {28'h0, ev, 2'h0});
            idle();
            chk(ctl_out === ctl, "control outputs");
            chk({aux_bus_read_strobe, aux_bus_write_strobe} === {2{ctl[5]}}, "strobes");
        end
        // error status: lane 0 and zero writes keep it, a new error beats the clear
        eeprom_error_event = 1'b1;
        err = 1'b1;
        idle();
        eeprom_error_event = 1'b0;
        rd(GPIRQ_OFS_MISC, mexp());
        wr(GPIRQ_OFS_MISC, 4'h1, {18'h1, 8'h0, ctl});
        wr(GPIRQ_OFS_MISC, 4'h2, 32'h0);
        rd(GPIRQ_OFS_MISC, mexp());
        wr(GPIRQ_OFS_MISC, 4'h2, 32'h4000);
        eeprom_error_event = 1'b1;
        err = 1'b1;
        rd(GPIRQ_OFS_MISC, mexp());
        eeprom_error_event = 1'b0;
        wr(GPIRQ_OFS_MISC, 4'h2, 32'h4000);
        rd(GPIRQ_OFS_MISC, mexp());
        // enable low: nothing taken, no ack, no change; two idles let ack fall first
        repeat (2) idle();
        clk_en = 1'b0;
        wr(GPIRQ_OFS_MISC, 4'h1, {26'h0, ~ctl});
        rd(GPIRQ_OFS_MISC, 32'h0);
        idle();
        clk_en = 1'b1;
        rd(GPIRQ_OFS_MISC, mexp());
        idle();
        // all four type pairs, random selects; low level flags while low, change pulses
        for (int i = 0; i < 8; i++) begin
            @(negedge sys_clk);
            rnd = lfsr(rnd);
            pin2_is_event_input = rnd[0];
            pin3_is_event_input = rnd[1];
            wr(GPIRQ_OFS_EVENT_TYPE, 4'h1, {28'h0, i[1:0], 2'h0});
            repeat (4) idle();
            gpio2_pin = 1'b0;
            gpio3_pin = 1'b0;
            repeat (3) @(posedge sys_clk);
            #1;
            chk({pin3_event_flag, pin2_event_flag} === rnd[1:0], "flag on fall");
            @(posedge sys_clk);
            #1;
            chk({pin3_event_flag, pin2_event_flag} === (rnd[1:0] & ~i[1:0]), "low");
            @(negedge sys_clk);
            gpio2_pin = 1'b1;
            gpio3_pin = 1'b1;
            repeat (3) @(posedge sys_clk);
            #1;
            chk({pin3_event_flag, pin2_event_flag} === (rnd[1:0] & i[1:0]), "rise");
            @(posedge sys_clk);
            #1;
            chk({pin3_event_flag, pin2_event_flag} === 2'h0, "flag after rise");
        end
        repeat (2) idle();
        chk(exp_q.size() == 0, "missing ack");
        results();
    end
endmodule

`default_nettype wire
